/* File: rtl/front_panel_pkg.sv */
/*
 front panel controller package: timing, register map, field layout,
 enumerations and the carrier structs shared by the panel logic.
 assumes a 100 MHz reference clock and a 32-bit Avalon-MM register slave.
*/
package front_panel_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1_000_000;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOUNCE_MS = 100;
	localparam int LONG_PRESS_MS = 2000;
	localparam int MODE_DELAY_MS = 4000;
	localparam int FAULT_TONE_MS = 10000;
	localparam int EVENT_TONE_MS = 3000;
	localparam int ALARM_BEEP_MS = 60000;
	localparam int BEEP_PERIOD_MS = 1000;
	localparam int BEEP_ON_MS = 500;
	localparam int FLASH_HALF_MS = 500;

	// ==========================================================
	// keys, pages, settings
	localparam int KEY_COUNT = 4;
	localparam int KEY_ESC = 0;
	localparam int KEY_UP = 1;
	localparam int KEY_DOWN = 2;
	localparam int KEY_ENTER = 3;
	localparam logic [3:0] PAGE_LAST = 4'h9;
	localparam int BAR_STEP_PCT = 25;
	localparam logic [1:0] VOLT_RESET = 2'h2;
	localparam logic [3:0] CUTOFF_RESET = 4'h0;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] SETTING_OFS = 4'h8;
	localparam int CTRL_MUTE_BIT = 0;
	localparam int STAT_PAGE_LSB = 0;
	localparam int STAT_UI_LSB = 4;
	localparam int STAT_SEL_BIT = 6;
	localparam int STAT_MODE_LSB = 8;
	localparam int STAT_MODE_VALID_BIT = 10;
	localparam int STAT_BUZZ_BIT = 11;
	localparam int STAT_SHUTDOWN_BIT = 12;
	localparam int SET_VOLT_LSB = 0;
	localparam int SET_CUTOFF_LSB = 4;
	localparam logic MUTE_RESET = 1'b0;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {MODE_STANDBY, MODE_GRID, MODE_BATTERY, MODE_FAULT} op_mode_t;
	typedef enum logic [1:0] {UI_PAGES, UI_SELECT, UI_EDIT} ui_t;
	typedef enum logic [1:0] {BUZZ_IDLE, BUZZ_FAULT, BUZZ_EVENT, BUZZ_ALARM} buzz_t;
	typedef enum logic [1:0] {SHOW_OUTPUT, SHOW_FAULT_CODE, SHOW_SETTING} numeric_t;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic gridOk;
		logic gridSupplying;
		logic batteryMode;
		logic floatCharge;
		logic cvCharge;
		logic fault;
		logic alarm;
		logic lowBatAlarm;
		logic overload;
		logic batLow;
		logic batAbsent;
		logic inputPresent;
		logic mainSwitch;
		logic powerKey;
		logic [7:0] loadPct;
		logic [7:0] batPct;
		logic [7:0] faultCode;
	} status_in_t;

	typedef struct packed {
		logic gridLed;
		logic inverting_indicator;
		logic charge_indicator;
		logic faultLed;
		logic [3:0] loadBar;
		logic [3:0] batBar;
		logic loadIcon;
		logic batIcon;
		logic muteIcon;
		logic settingsIcon;
		logic faultIcon;
		logic modeValid;
		op_mode_t modeShown;
		numeric_t numericSel;
		logic [3:0] page;
		logic [7:0] faultCodeShown;
		logic buzzer;
		logic shutdownReq;
	} panel_out_t;

	typedef struct packed {
		logic [1:0] output_voltage_setting;
		logic [3:0] battery_cutoff_point;
	} setting_t;

	typedef struct packed {
		logic [16:0] tickCnt;
		logic tick;
		logic [KEY_COUNT-1:0][11:0] holdMs;
		logic [9:0] flashMs;
		logic flash;
		logic [12:0] startMs;
		ui_t ui;
		logic sel;
		setting_t setting;
		logic mute;
		buzz_t buzz;
		logic [15:0] buzzMs;
		logic [9:0] beepMs;
		logic faultPrev;
		logic alarmPrev;
		logic inputPrev;
		logic switchPrev;
		logic powerPrev;
		logic waitrequest;
		logic [31:0] readdata;
		panel_out_t out;
	} state_t;

endpackage : front_panel_pkg

/* File: rtl/front_panel_status_controller.sv */
/*
 front panel status controller: key hold decoding, page and setting
 navigation, status leds, lcd icons and working-mode area, buzzer patterns,
 and an Avalon-MM register slave.
 assumes keys and status inputs are synchronous to ref_clk, keys high while
 pressed, and a master that holds each request until waitrequest is low.
*/
// The Avalon-MM register port and the register offsets were decided locally.
//
// Behaviour
// - enter held over two seconds on a display page opens function setting
// - in setting, up or down moves selection backward or forward
// - in setting, enter pressed 0.1 to 2 s confirms the chosen option
// - up or down held over 0.1 s turns to previous or next page
// - escape leaves setting; enter opens or confirms; up previous, down next
// - grid led solid when supplying, flashing when idle-normal, dark if abnormal
// - inverting led solid only in battery mode
// - charge led solid floating, flashing constant-voltage, else dark
// - fault led solid on fault, flashing on alarm, dark otherwise
// - each bar segment stands for 25 percent of capacity
// - load icon blinks on overload; battery icon blinks when low or absent
// - mute silences buzzer and shows muted icon, hidden otherwise
// - settings icon lit only while settings menu open
// - fault icon shown only in fault mode
// - outside setting, numeric area shows output info or fault code
// - working-mode area shows mode from four seconds after start-up
// - fault entry gives one ten second continuous tone
// - input loss, recovery or main switch change gives three second tone
// - other alarms beep once a second for a minute; low battery only in battery mode
// - mute is accepted in any mode
// - power key press in battery or grid mode shuts system down

`timescale 1ns/1ns

module front_panel_status_controller #(
	parameter int tickCycles = front_panel_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [front_panel_pkg::KEY_COUNT-1:0] keys,
	input wire front_panel_pkg::status_in_t status,
	output front_panel_pkg::panel_out_t panel,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest
);

	// ==========================================================
	// state
	localparam logic [16:0] TICK_LAST = 17'(tickCycles - 1);
	localparam logic [11:0] BOUNCE = 12'(front_panel_pkg::BOUNCE_MS);
	localparam logic [11:0] LONG = 12'(front_panel_pkg::LONG_PRESS_MS);

	front_panel_pkg::state_t s;
	front_panel_pkg::state_t n;

	logic [front_panel_pkg::KEY_COUNT-1:0] keyShort;
	logic [front_panel_pkg::KEY_COUNT-1:0] keyHeld;
	logic [front_panel_pkg::KEY_COUNT-1:0] keyLong;

	// ==========================================================
	// key decode
	// the hold count is still valid in the cycle the key is seen released
	genvar k;
	generate
		for (k = 0; k < front_panel_pkg::KEY_COUNT; k++)
		begin : gKey
			assign keyHeld[k] = !keys[k] && s.holdMs[k] >= BOUNCE;
			assign keyShort[k] = keyHeld[k] && s.holdMs[k] <= LONG;
			assign keyLong[k] = keys[k] && s.tick && s.holdMs[k] == LONG;
		end
	endgenerate

	// ==========================================================
	// next state
	always_comb
	begin
		front_panel_pkg::op_mode_t mode;
		logic alarmQual;
		logic busAck;
		logic [31:0] rd;
		mode = front_panel_pkg::MODE_STANDBY;
		alarmQual = 1'b0;
		busAck = 1'b0;
		rd = 32'h0000_0000;
		n = s;

		// millisecond timebase and flash phase
		n.tick = 1'b0;
		if (s.tickCnt == TICK_LAST)
		begin
			n.tickCnt = 17'h0_0000;
			n.tick = 1'b1;
		end
		else
		begin
			n.tickCnt = s.tickCnt + 17'h0_0001;
		end
		if (s.tick)
		begin
			if (s.flashMs == 10'(front_panel_pkg::FLASH_HALF_MS - 1))
			begin
				n.flashMs = 10'h000;
				n.flash = !s.flash;
			end
			else
			begin
				n.flashMs = s.flashMs + 10'h001;
			end
			if (s.startMs != 13'(front_panel_pkg::MODE_DELAY_MS))
			begin
				n.startMs = s.startMs + 13'h0001;
			end
		end

		// hold timers, saturating so long holds never wrap into a short one
		for (int i = 0; i < front_panel_pkg::KEY_COUNT; i++)
		begin
			if (!keys[i])
			begin
				n.holdMs[i] = 12'h000;
			end
			else if (s.tick && s.holdMs[i] != 12'hFFF)
			begin
				n.holdMs[i] = s.holdMs[i] + 12'h001;
			end
		end

		// operating mode, fault first
		if (status.fault)
		begin
			mode = front_panel_pkg::MODE_FAULT;
		end
		else if (status.batteryMode)
		begin
			mode = front_panel_pkg::MODE_BATTERY;
		end
		else if (status.gridSupplying)
		begin
			mode = front_panel_pkg::MODE_GRID;
		end

		// navigation
		case (s.ui)
			front_panel_pkg::UI_PAGES:
			begin
				if (keyLong[front_panel_pkg::KEY_ENTER])
				begin
					n.ui = front_panel_pkg::UI_SELECT;
					n.sel = 1'b0;
				end
				else if (keyHeld[front_panel_pkg::KEY_UP])
				begin
					n.out.page = (s.out.page == 4'h0) ? front_panel_pkg::PAGE_LAST
						: s.out.page - 4'h1;
				end
				else if (keyHeld[front_panel_pkg::KEY_DOWN])
				begin
					n.out.page = (s.out.page == front_panel_pkg::PAGE_LAST) ? 4'h0
						: s.out.page + 4'h1;
				end
			end
			front_panel_pkg::UI_SELECT:
			begin
				if (keyShort[front_panel_pkg::KEY_ESC])
				begin
					n.ui = front_panel_pkg::UI_PAGES;
					n.out.page = 4'h0;
				end
				else if (keyShort[front_panel_pkg::KEY_ENTER])
				begin
					n.ui = front_panel_pkg::UI_EDIT;
				end
				else if (keyHeld[front_panel_pkg::KEY_UP] || keyHeld[front_panel_pkg::KEY_DOWN])
				begin
					n.sel = !s.sel; // two items, so previous and next coincide
				end
			end
			front_panel_pkg::UI_EDIT:
			begin
				if (keyShort[front_panel_pkg::KEY_ESC])
				begin
					n.ui = front_panel_pkg::UI_PAGES;
					n.out.page = 4'h0;
				end
				else if (keyShort[front_panel_pkg::KEY_ENTER])
				begin
					n.ui = front_panel_pkg::UI_SELECT;
				end
				else if (keyHeld[front_panel_pkg::KEY_UP])
				begin
					if (s.sel)
					begin
						n.setting.battery_cutoff_point = s.setting.battery_cutoff_point - 4'h1;
					end
					else
					begin
						n.setting.output_voltage_setting = s.setting.output_voltage_setting - 2'h1;
					end
				end
				else if (keyHeld[front_panel_pkg::KEY_DOWN])
				begin
					if (s.sel)
					begin
						n.setting.battery_cutoff_point = s.setting.battery_cutoff_point + 4'h1;
					end
					else
					begin
						n.setting.output_voltage_setting = s.setting.output_voltage_setting + 2'h1;
					end
				end
			end
			default:
			begin
				n.ui = front_panel_pkg::UI_PAGES;
			end
		endcase

		// buzzer patterns: a newer event of equal or higher rank restarts
		alarmQual = status.alarm || (status.lowBatAlarm && status.batteryMode);
		n.faultPrev = status.fault;
		n.alarmPrev = alarmQual;
		n.inputPrev = status.inputPresent;
		n.switchPrev = status.mainSwitch;
		if (s.tick && s.buzz != front_panel_pkg::BUZZ_IDLE)
		begin
			n.buzzMs = s.buzzMs - 16'h0001;
			n.beepMs = (s.beepMs == 10'(front_panel_pkg::BEEP_PERIOD_MS - 1)) ? 10'h000
				: s.beepMs + 10'h001;
			if (s.buzzMs == 16'h0001)
			begin
				n.buzz = front_panel_pkg::BUZZ_IDLE;
			end
		end
		if (status.fault && !s.faultPrev)
		begin
			n.buzz = front_panel_pkg::BUZZ_FAULT;
			n.buzzMs = 16'(front_panel_pkg::FAULT_TONE_MS);
		end
		else if (s.buzz != front_panel_pkg::BUZZ_FAULT
			&& (status.inputPresent != s.inputPrev || status.mainSwitch != s.switchPrev))
		begin
			n.buzz = front_panel_pkg::BUZZ_EVENT;
			n.buzzMs = 16'(front_panel_pkg::EVENT_TONE_MS);
		end
		else if ((s.buzz == front_panel_pkg::BUZZ_IDLE || s.buzz == front_panel_pkg::BUZZ_ALARM)
			&& alarmQual && !s.alarmPrev)
		begin
			n.buzz = front_panel_pkg::BUZZ_ALARM;
			n.buzzMs = 16'(front_panel_pkg::ALARM_BEEP_MS);
			n.beepMs = 10'h000;
		end
		else if (s.buzz == front_panel_pkg::BUZZ_ALARM && !alarmQual)
		begin
			n.buzz = front_panel_pkg::BUZZ_IDLE; // low battery beeps stop outside battery mode
		end

		// power key: a fresh press while running asks for shutdown
		n.powerPrev = status.powerKey;
		if (status.powerKey && !s.powerPrev
			&& (mode == front_panel_pkg::MODE_BATTERY || mode == front_panel_pkg::MODE_GRID))
		begin
			n.out.shutdownReq = 1'b1;
		end

		// ==========================================================
		// register slave: one wait cycle, then a one-cycle acknowledge
		busAck = (read || write) && s.waitrequest;
		n.waitrequest = !busAck;
		rd[front_panel_pkg::CTRL_MUTE_BIT] = s.mute;
		if (address == front_panel_pkg::STATUS_OFS)
		begin
			rd = 32'h0000_0000;
			rd[front_panel_pkg::STAT_PAGE_LSB +: 4] = s.out.page;
			rd[front_panel_pkg::STAT_UI_LSB +: 2] = s.ui;
			rd[front_panel_pkg::STAT_SEL_BIT] = s.sel;
			rd[front_panel_pkg::STAT_MODE_LSB +: 2] = mode;
			rd[front_panel_pkg::STAT_MODE_VALID_BIT] = s.out.modeValid;
			rd[front_panel_pkg::STAT_BUZZ_BIT] = s.out.buzzer;
			rd[front_panel_pkg::STAT_SHUTDOWN_BIT] = s.out.shutdownReq;
		end
		else if (address == front_panel_pkg::SETTING_OFS)
		begin
			rd = 32'h0000_0000;
			rd[front_panel_pkg::SET_VOLT_LSB +: 2] = s.setting.output_voltage_setting;
			rd[front_panel_pkg::SET_CUTOFF_LSB +: 4] = s.setting.battery_cutoff_point;
		end
		else if (address != front_panel_pkg::CTRL_OFS)
		begin
			rd = 32'h0000_0000;
		end
		n.readdata = (busAck && read) ? rd : 32'h0000_0000;
		if (write && !s.waitrequest && byteenable[0])
		begin
			if (address == front_panel_pkg::CTRL_OFS)
			begin
				n.mute = writedata[front_panel_pkg::CTRL_MUTE_BIT];
			end
			else if (address == front_panel_pkg::SETTING_OFS)
			begin
				n.setting.output_voltage_setting = writedata[front_panel_pkg::SET_VOLT_LSB +: 2];
				n.setting.battery_cutoff_point = writedata[front_panel_pkg::SET_CUTOFF_LSB +: 4];
			end
		end

		// ==========================================================
		// indicators and lcd
		n.out.gridLed = status.gridOk && (status.gridSupplying || s.flash);
		n.out.inverting_indicator = (mode == front_panel_pkg::MODE_BATTERY);
		n.out.charge_indicator = status.floatCharge || (status.cvCharge && s.flash);
		n.out.faultLed = status.fault || (status.alarm && s.flash);
		for (int i = 0; i < 4; i++)
		begin
			n.out.loadBar[i] = status.loadPct >= 8'(front_panel_pkg::BAR_STEP_PCT * (i + 1));
			n.out.batBar[i] = status.batPct >= 8'(front_panel_pkg::BAR_STEP_PCT * (i + 1));
		end
		n.out.loadIcon = !status.overload || s.flash;
		n.out.batIcon = !(status.batLow || status.batAbsent) || s.flash;
		n.out.muteIcon = s.mute;
		n.out.settingsIcon = (s.ui != front_panel_pkg::UI_PAGES);
		n.out.faultIcon = (mode == front_panel_pkg::MODE_FAULT);
		if (s.ui != front_panel_pkg::UI_PAGES)
		begin
			n.out.numericSel = front_panel_pkg::SHOW_SETTING;
		end
		else if (mode == front_panel_pkg::MODE_FAULT)
		begin
			n.out.numericSel = front_panel_pkg::SHOW_FAULT_CODE;
		end
		else
		begin
			n.out.numericSel = front_panel_pkg::SHOW_OUTPUT;
		end
		n.out.faultCodeShown = status.fault ? status.faultCode : 8'h00;
		n.out.modeValid = (s.startMs == 13'(front_panel_pkg::MODE_DELAY_MS));
		n.out.modeShown = mode;
		case (s.buzz)
			front_panel_pkg::BUZZ_FAULT,
			front_panel_pkg::BUZZ_EVENT:
			begin
				n.out.buzzer = !s.mute;
			end
			front_panel_pkg::BUZZ_ALARM:
			begin
				n.out.buzzer = !s.mute && s.beepMs < 10'(front_panel_pkg::BEEP_ON_MS);
			end
			default:
			begin
				n.out.buzzer = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.waitrequest <= 1'b1;
			s.mute <= front_panel_pkg::MUTE_RESET;
			s.setting.output_voltage_setting <= front_panel_pkg::VOLT_RESET;
			s.setting.battery_cutoff_point <= front_panel_pkg::CUTOFF_RESET;
			s.out.loadIcon <= 1'b1;
			s.out.batIcon <= 1'b1;
		end
		else
		begin
			s <= n;
		end
	end

	assign panel = s.out;
	assign readdata = s.readdata;
	assign waitrequest = s.waitrequest;

endmodule : front_panel_status_controller

/* File: testbench/panel_user_model.sv */
/*
 front panel user model: presses one key for a whole number of milliseconds.
 assumes key bits esc, up, down, enter from bit 0 and msCycles clocks per ms.
*/
`timescale 1ns/1ns

module panel_user_model #(
	parameter int msCycles = 2
) (
	input wire logic ref_clk,
	output logic [front_panel_pkg::KEY_COUNT-1:0] keys
);
	initial keys = '0;

	// ==========================================================
	// key press
	// settle after release covers the two-edge page update
	task automatic press(input int k, input int ms);
	begin
		@(posedge ref_clk);
		keys[k] <= 1'b1;
		repeat (ms * msCycles) @(posedge ref_clk);
		keys[k] <= 1'b0;
		repeat (8) @(posedge ref_clk);
	end
	endtask : press
endmodule : panel_user_model

/* File: testbench/front_panel_asserts.sv */
/*
 front panel checker: properties on the top module ports.
 assumes one clock domain, ref_clk, with synchronous active-low resetn.
*/
`timescale 1ns/1ns

module front_panel_asserts #(
	parameter int tickCycles = 2
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [front_panel_pkg::KEY_COUNT-1:0] keys,
	input wire front_panel_pkg::status_in_t status,
	input wire front_panel_pkg::panel_out_t panel,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	localparam int modeCycles = front_panel_pkg::MODE_DELAY_MS * tickCycles;
	logic [31:0] upCnt;

	// ==========================================================
	// cycles since reset release, saturating
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			upCnt <= 32'h0000_0000;
		else if (upCnt != 32'hFFFF_FFFF)
			upCnt <= upCnt + 32'h0000_0001;
	end

	// ==========================================================
	// bus handshake
	sequence s_req;
		(read || write) && waitrequest;
	endsequence
	sequence s_ack;
		!waitrequest ##1 waitrequest;
	endsequence
	chk_bus_one_wait: assert property (s_req |=> s_ack)
		else $error("bus answer not after one wait state");
	chk_idle_rdata: assert property (waitrequest |-> readdata == 32'h0000_0000)
		else $error("read data not zero while waiting");
	chk_ack_caused: assert property (!waitrequest |-> $past(read || write))
		else $error("acknowledge without request");

	// ==========================================================
	// indicators and icons
	chk_inv_on: assert property ((status.batteryMode && !status.fault)[*3] |-> panel.inverting_indicator)
		else $error("inverting led dark in battery mode");
	chk_inv_off: assert property ((!status.batteryMode)[*3] |-> !panel.inverting_indicator)
		else $error("inverting led lit outside battery mode");
	chk_fault_icon: assert property ($stable(status.fault)[*3] |-> panel.faultIcon == status.fault)
		else $error("fault icon does not follow fault mode");
	chk_fault_led: assert property (status.fault[*3] |-> panel.faultLed)
		else $error("fault led not solid in fault");
	chk_grid_solid: assert property ((status.gridOk && status.gridSupplying)[*3] |-> panel.gridLed)
		else $error("grid led not solid while supplying");
	chk_grid_dark: assert property ((!status.gridOk)[*3] |-> !panel.gridLed)
		else $error("grid led lit with grid abnormal");
	chk_bar_half: assert property ((status.loadPct == 8'h32)[*3] |-> panel.loadBar == 4'h3)
		else $error("load bar wrong at half load");
	chk_mute_quiet: assert property (panel.muteIcon[*2] |-> !panel.buzzer)
		else $error("buzzer sounds while muted");
	chk_event_tone: assert property ($changed(status.mainSwitch) && !status.fault && !panel.muteIcon
		&& !panel.buzzer |-> ##[1:3] panel.buzzer)
		else $error("no tone on main switch change");
	chk_shut_hold: assert property (panel.shutdownReq |=> panel.shutdownReq)
		else $error("shutdown request dropped");
	chk_mode_hidden: assert property (upCnt < 32'(modeCycles - 2) |-> !panel.modeValid)
		else $error("mode shown too early");
	chk_mode_shown: assert property (upCnt > 32'(modeCycles + 8) |-> panel.modeValid)
		else $error("mode not shown after start-up delay");
endmodule : front_panel_asserts

bind front_panel_status_controller front_panel_asserts #(.tickCycles(tickCycles)) chk (
	.ref_clk(ref_clk), .resetn(resetn), .keys(keys), .status(status), .panel(panel),
	.address(address), .read(read), .write(write), .byteenable(byteenable),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest)
);

/* File: testbench/front_panel_status_controller_tb.sv */
/*
 front panel testbench: keys through the user model, status and bus here.
 assumes a shortened tick of TC clocks per ms; expectations scale with it.
*/
`timescale 1ns/1ns

module front_panel_status_controller_tb;
	localparam int TC = 2;
	logic ref_clk;
	logic resetn;
	logic [front_panel_pkg::KEY_COUNT-1:0] keys;
	front_panel_pkg::status_in_t status;
	front_panel_pkg::panel_out_t panel;
	front_panel_pkg::panel_out_t orv;
	front_panel_pkg::panel_out_t andv;
	logic [3:0] address;
	logic read;
	logic write;
	logic [3:0] byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic [31:0] rd;
	int err_total;
	int n_checks;

	front_panel_status_controller #(.tickCycles(TC)) uut (
		.ref_clk(ref_clk), .resetn(resetn), .keys(keys), .status(status), .panel(panel),
		.address(address), .read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest)
	);
	panel_user_model #(.msCycles(TC)) usr (
		.ref_clk(ref_clk),
		.keys(keys)
	);

	// ==========================================================
	// shared tasks
	task automatic conclude;
	begin
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask : conclude
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
	begin
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	end
	endtask : cmp

	// one Avalon-MM access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
	begin
		n = 0;
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 20);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0)
		begin
			err_total++;
			$display("unexpected at %0t: bus hang", $time);
			conclude;
		end
	end
	endtask : bus

	// or and and of settled panel bits: solid, flashing, dark
	task automatic look(input int ms);
	begin
		orv = '0;
		andv = '1;
		@(posedge ref_clk);
		repeat (ms * TC)
		begin
			@(posedge ref_clk);
			orv = orv | panel;
			andv = andv & panel;
		end
	end
	endtask : look

	// ==========================================================
	// scenarios
	task automatic t_regs;
	begin
		bus(1'b0, 4'h0, 32'h0000_0000);
		cmp(rd, 32'h0000_0000, "mute reset");
		bus(1'b0, 4'h8, 32'h0000_0000);
		cmp(rd, 32'h0000_0002, "setting reset");
		bus(1'b1, 4'h0, 32'h0000_0001);
		bus(1'b0, 4'h0, 32'h0000_0000);
		cmp(rd, 32'h0000_0001, "mute readback");
		repeat (4) @(posedge ref_clk);
		cmp({31'h0, panel.muteIcon}, 32'h0000_0001, "mute icon on");
		bus(1'b1, 4'h0, 32'h0000_0000);
		repeat (4) @(posedge ref_clk);
		cmp({31'h0, panel.muteIcon}, 32'h0000_0000, "mute icon off");
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0000_0000);
		cmp(rd, 32'h0000_0000, "unmapped read");
		$display("test regs done");
	end
	endtask : t_regs

	task automatic t_pages;
	begin
		usr.press(2, 150);
		cmp({28'h0, panel.page}, 32'h0000_0001, "page next");
		usr.press(1, 150);
		usr.press(1, 150);
		cmp({28'h0, panel.page}, 32'h0000_0009, "page wrap back");
		usr.press(2, 50);
		cmp({28'h0, panel.page}, 32'h0000_0009, "bounce ignored");
		usr.press(2, 150);
		cmp({28'h0, panel.page}, 32'h0000_0000, "page wrap on");
		$display("test pages done");
	end
	endtask : t_pages

	task automatic t_setting;
	begin
		usr.press(3, 2100);
		cmp({31'h0, panel.settingsIcon}, 32'h0000_0001, "settings icon");
		bus(1'b0, 4'h4, 32'h0000_0000);
		cmp({25'h0, rd[6:0]} & 32'h0000_0070, 32'h0000_0010, "select entered");
		usr.press(2, 150);
		bus(1'b0, 4'h4, 32'h0000_0000);
		cmp({25'h0, rd[6:0]} & 32'h0000_0070, 32'h0000_0050, "next item");
		usr.press(3, 300);
		usr.press(1, 300);
		bus(1'b0, 4'h8, 32'h0000_0000);
		cmp(rd, 32'h0000_00F2, "cutoff decrement wraps");
		usr.press(0, 300);
		bus(1'b0, 4'h4, 32'h0000_0000);
		cmp({25'h0, rd[6:0]} & 32'h0000_0030, 32'h0000_0000, "setting left");
		cmp({31'h0, panel.settingsIcon}, 32'h0000_0000, "settings icon off");
		$display("test setting done");
	end
	endtask : t_setting

	task automatic t_buzz;
	begin
		status.mainSwitch <= 1'b1;
		repeat (2900 * TC) @(posedge ref_clk);
		cmp({31'h0, panel.buzzer}, 32'h0000_0001, "event tone on");
		repeat (200 * TC) @(posedge ref_clk);
		cmp({31'h0, panel.buzzer}, 32'h0000_0000, "event tone off");
		status.alarm <= 1'b1;
		look(1100);
		cmp({30'h0, orv.buzzer, andv.buzzer}, 32'h0000_0002, "alarm beeps");
		cmp({30'h0, orv.faultLed, andv.faultLed}, 32'h0000_0002, "alarm flash");
		bus(1'b1, 4'h0, 32'h0000_0001);
		look(1100);
		cmp({31'h0, orv.buzzer}, 32'h0000_0000, "muted alarm");
		status.alarm <= 1'b0;
		status.lowBatAlarm <= 1'b1;
		bus(1'b1, 4'h0, 32'h0000_0000);
		look(1100);
		cmp({31'h0, orv.buzzer}, 32'h0000_0000, "low battery quiet");
		status.batteryMode <= 1'b1;
		look(1100);
		cmp({31'h0, orv.buzzer}, 32'h0000_0001, "low battery beeps");
		cmp({31'h0, andv.inverting_indicator}, 32'h0000_0001, "inverting solid");
		status.lowBatAlarm <= 1'b0;
		status.batteryMode <= 1'b0;
		status.faultCode <= 8'h5A;
		status.fault <= 1'b1;
		repeat (9900 * TC) @(posedge ref_clk);
		cmp({31'h0, panel.buzzer}, 32'h0000_0001, "fault tone on");
		cmp({31'h0, panel.faultIcon}, 32'h0000_0001, "fault icon");
		cmp({24'h0, panel.faultCodeShown}, 32'h0000_005A, "fault code");
		cmp(32'(panel.numericSel), 32'(front_panel_pkg::SHOW_FAULT_CODE), "fault area");
		cmp(32'(panel.modeShown), 32'(front_panel_pkg::MODE_FAULT), "fault mode");
		repeat (200 * TC) @(posedge ref_clk);
		cmp({31'h0, panel.buzzer}, 32'h0000_0000, "fault tone off");
		status.fault <= 1'b0;
		repeat (4) @(posedge ref_clk);
		cmp(32'(panel.numericSel), 32'(front_panel_pkg::SHOW_OUTPUT), "output area");
		$display("test buzzer done");
	end
	endtask : t_buzz

	task automatic t_leds;
	begin
		status.gridOk <= 1'b1;
		status.gridSupplying <= 1'b1;
		status.floatCharge <= 1'b1;
		status.loadPct <= 8'h32;
		status.batPct <= 8'h64;
		look(1100);
		cmp({31'h0, andv.gridLed}, 32'h0000_0001, "grid solid");
		cmp({31'h0, andv.charge_indicator}, 32'h0000_0001, "float solid");
		cmp({24'h0, panel.loadBar, panel.batBar}, 32'h0000_003F, "bars");
		cmp(32'(panel.modeShown), 32'(front_panel_pkg::MODE_GRID), "grid mode");
		status.gridSupplying <= 1'b0;
		status.floatCharge <= 1'b0;
		status.cvCharge <= 1'b1;
		status.overload <= 1'b1;
		status.batAbsent <= 1'b1;
		look(1100);
		cmp({30'h0, orv.gridLed, andv.gridLed}, 32'h0000_0002, "grid flash");
		cmp({30'h0, orv.charge_indicator, andv.charge_indicator}, 32'h0000_0002, "cv flash");
		cmp({30'h0, orv.loadIcon, andv.loadIcon}, 32'h0000_0002, "load blink");
		cmp({30'h0, orv.batIcon, andv.batIcon}, 32'h0000_0002, "battery blink");
		status.gridOk <= 1'b0;
		status.cvCharge <= 1'b0;
		status.overload <= 1'b0;
		status.batAbsent <= 1'b0;
		look(1100);
		cmp({30'h0, orv.gridLed, orv.charge_indicator}, 32'h0000_0000, "leds dark");
		cmp({30'h0, andv.loadIcon, andv.batIcon}, 32'h0000_0003, "icons steady");
		$display("test leds done");
	end
	endtask : t_leds

	task automatic t_shutdown;
	begin
		status.powerKey <= 1'b1;
		repeat (4) @(posedge ref_clk);
		cmp({31'h0, panel.shutdownReq}, 32'h0000_0000, "standby no shutdown");
		status.powerKey <= 1'b0;
		status.gridOk <= 1'b1;
		status.gridSupplying <= 1'b1;
		repeat (4) @(posedge ref_clk);
		status.powerKey <= 1'b1;
		repeat (4) @(posedge ref_clk);
		cmp({31'h0, panel.shutdownReq}, 32'h0000_0001, "grid shutdown");
		$display("test shutdown done");
	end
	endtask : t_shutdown

	// ==========================================================
	// clock, sequence, watchdog
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial
	begin
		resetn = 1'b0;
		status = '0;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hF;
		writedata = 32'h0000_0000;
		err_total = 0;
		n_checks = 0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		cmp({31'h0, panel.modeValid}, 32'h0000_0000, "mode hidden");
		t_regs;
		t_pages;
		t_setting;
		t_buzz;
		t_leds;
		t_shutdown;
		conclude;
	end

	initial
	begin
		repeat (100000) @(posedge ref_clk);
		err_total++;
		$display("unexpected at %0t: run too long", $time);
		conclude;
	end
endmodule : front_panel_status_controller_tb
